// ==== dpsa_consts.svh ====
`ifndef DPSA_CONSTS_SVH
`define DPSA_CONSTS_SVH

// Clock and pin timing, figures in ns
`define DPSA_CLK_NS     10
`define DPSA_ACCESS_NS  25
`define DPSA_FLOW_NS    30
`define DPSA_SOP_NS     10
`define DPSA_CYC(ns)    (((ns) + `DPSA_CLK_NS - 1) / `DPSA_CLK_NS)
`define DPSA_WR_CYC     `DPSA_CYC(`DPSA_ACCESS_NS)
`define DPSA_RD_CYC     `DPSA_CYC((`DPSA_FLOW_NS > `DPSA_ACCESS_NS) ? \
                                  `DPSA_FLOW_NS : `DPSA_ACCESS_NS)
`define DPSA_GAP_CYC    `DPSA_CYC(`DPSA_SOP_NS)

// Field widths and bit positions
`define DPSA_DW         16
`define DPSA_AW         15
`define DPSA_SEM_AW     3
`define DPSA_SEM_BIT    0
`define DPSA_TMR_W      8

`endif

// ==== dpsa_dev_model.sv ====
`timescale 1ns/1ns
module dpsa_dev_model (
    // Port pins
    input  wire logic        sys_clk,
    input  wire logic        csLo_b,
    input  wire logic        csHi,
    input  wire logic        rnw,
    input  wire logic        oe_b,
    input  wire logic        ub_b,
    input  wire logic        lb_b,
    input  wire logic        sem_b,
    input  wire logic [14:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata,
    output logic             busy_b,
    output logic             int_b,
    // Far port stand-in
    input  wire logic        peerBusy,
    input  wire logic [7:0]  peerSem,
    input  wire logic        peerMbxWr
);
    logic [15:0] mem [0:32767];
    logic [15:0] lastQ = 16'h0000;
    logic [7:0]  hostOwn = 8'h00;
    logic [7:0]  pend = 8'h00;
    logic        irq = 1'b0;
    logic        sel;
    logic        semSel;
    logic        drv;
    logic [15:0] rdVal;

    assign sel    = !csLo_b && csHi;
    assign semSel = !sem_b && !sel;
    assign drv    = (sel || semSel) && rnw && !oe_b;
    // Ungated lanes float, so show the inverse of the last value
    assign rdVal  = semSel ? {16{~hostOwn[addr[2:0]]}}
                  : {ub_b ? ~lastQ[15:8] : mem[addr][15:8],
                     lb_b ? ~lastQ[7:0] : mem[addr][7:0]};
    assign rdata  = drv ? rdVal : ~lastQ;
    assign busy_b = !(sel && peerBusy);
    assign int_b  = !irq;

    always @(posedge sys_clk)
    begin
        if (drv)
            lastQ <= rdVal;
        if (sel && !rnw && !peerBusy)
        begin
            if (!ub_b)
                mem[addr][15:8] <= wdata[15:8];
            if (!lb_b)
                mem[addr][7:0] <= wdata[7:0];
        end
        if (peerMbxWr)
            irq <= 1'b1;
        else if (drv && sel && addr == 15'h7FFE)
            irq <= 1'b0;
        for (int i = 0; i < 8; i++)
            if (pend[i] && !peerSem[i])
            begin
                hostOwn[i] <= 1'b1;
                pend[i] <= 1'b0;
            end
        if (semSel && !rnw)
        begin
            if (wdata[0])
            begin
                hostOwn[addr[2:0]] <= 1'b0;
                pend[addr[2:0]] <= 1'b0;
            end
            else if (peerSem[addr[2:0]])
                pend[addr[2:0]] <= 1'b1;
            else
                hostOwn[addr[2:0]] <= 1'b1;
        end
    end
endmodule // dpsa_dev_model

// ==== dpsa_host.sv ====
`timescale 1ns/1ns
`include "dpsa_consts.svh"
// Function
// [RL1] Port selected only with low-active select low and high-active select high.
// [RL2] Device decodes fifteen or sixteen address bits by size variant.
// [RL3] Upper byte gate controls the upper data byte.
// [RL4] Lower byte gate controls the lower data byte.
// [RL5] Both ports access any location independently, without a shared clock.
// [RL6] Device flags busy when both ports hit the same location.
// [RL7] Busy pins drive in master mode and receive in slave mode.
// [RL8] Devices combine through master and slave busy links for wider words.
// [RL9] Eight semaphore latches shared by both ports, apart from the array.
// [RL10] Each semaphore latch is owned by at most one port.
// [RL11] A port powers down while its select is inactive.
// [RL12] Read data is driven only while output enable is asserted.
// [RL13] Write ends on whichever of strobe or select ends first; data caught there.
// [RL14] Reader waits the flowthrough delay after a far-side write before sampling.
// [RL15] Each port has an interrupt flag for mailbox messages.
// [RL16] Top word is right mailbox, next is left; owner read clears interrupt.
// [RL17] Semaphore select replaces chip select; address bits 0-2, data bit 0.
// [RL18] Zero grants a free semaphore; pending request wins when owner writes one.
// [RL19] Near-simultaneous matching accesses: one port wins, other sees busy.
// [RL20] Device data lines float unless selected, output-enabled and reading.
module dpsa_host #(
    parameter int DW       = `DPSA_DW,
    parameter int AW       = `DPSA_AW,
    parameter bit RIGHT    = 1'b0,
    parameter int WR_CYC   = `DPSA_WR_CYC,
    parameter int RD_CYC   = `DPSA_RD_CYC,
    parameter int GAP_CYC  = `DPSA_GAP_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // User request
    input  wire logic              reqValid,
    input  dpsa_pkg::dpsa_cmd_t    reqCmd,
    input  wire logic [AW-1:0]     reqAddr,
    input  wire logic [DW-1:0]     reqData,
    input  wire logic              reqUpper,
    input  wire logic              reqLower,
    output logic                   reqReady,
    // User answer
    output logic                   respValid,
    output logic [DW-1:0]          respData,
    output logic                   respBusyHit,
    output logic                   mbxIrq,
    // Device port pins
    output logic                   portSelectLowActive_b,
    output logic                   portSelectHighActive,
    output logic                   readNotWrite,
    output logic                   outEnable_b,
    output logic                   upperByteGate_b,
    output logic                   lowerByteGate_b,
    output logic                   tokenLatchSelect_b,
    output logic [AW-1:0]          addrOut,
    output logic [DW-1:0]          dataOut,
    output logic                   dataOe,
    input  wire logic [DW-1:0]     dataIn,
    input  wire logic              busyIn_b,
    input  wire logic              intIn_b
);
    import dpsa_pkg::*;

    localparam int TW = `DPSA_TMR_W;

    if (!(DW == 16 || DW == 18) || !(AW == 15 || AW == 16)) // RL2 RL3 RL4
    begin : g_chk_size
        $error("DW must be 16 or 18 and AW 15 or 16");
    end
    if (WR_CYC < 1 || RD_CYC < 1 || GAP_CYC < 1 || RD_CYC >= 2**TW || WR_CYC >= 2**TW
        || GAP_CYC >= 2**TW)
    begin : g_chk_cyc
        $error("cycle counts out of timer range");
    end

    typedef struct packed {
        dpsa_state_t   state;
        logic          ce0b;
        logic          ce1;
        logic          rnw;
        logic          oeb;
        logic          ubb;
        logic          lbb;
        logic          semb;
        logic [AW-1:0] addr;
        logic [DW-1:0] dout;
        logic          doe;
        logic [DW-1:0] rdata;
        logic          respValid;
        logic          busyHit;
        logic          irq;
        logic          ready;
        logic          tmrStart;
        logic [TW-1:0] tmrLoad;
        logic [TW-1:0] rdCnt;
    } dpsa_st_t;

    localparam dpsa_st_t RST_ST = '{state: ST_IDLE, ce0b: 1'b1, rnw: 1'b1, oeb: 1'b1,
                                    ubb: 1'b1, lbb: 1'b1, semb: 1'b1, ready: 1'b1,
                                    default: '0};

    // Own mailbox sits on the top word for the right port, one below for the left
    function automatic logic [AW-1:0] mbxAddr(input logic peer);
        return (RIGHT ^ peer) ? {AW{1'b1}} : {{(AW-1){1'b1}}, 1'b0}; // RL16
    endfunction

    dpsa_st_t   s_q;
    dpsa_st_t   s_d;
    logic       isWr;
    logic       isSem;
    dpsa_tmr_if #(.CW(TW)) tmrIf ();

    always_comb
    begin
        s_d           = s_q;
        s_d.tmrStart  = 1'b0;
        s_d.respValid = 1'b0;
        s_d.irq       = ~intIn_b; // RL15
        s_d.rdCnt     = s_q.oeb ? '0 : s_q.rdCnt + 1'b1;
        isWr  = reqCmd inside {DPSA_WRITE, DPSA_SEM_WR, DPSA_MBX_WR};
        isSem = reqCmd inside {DPSA_SEM_RD, DPSA_SEM_WR};
        unique case (s_q.state)
            ST_IDLE:
                if (reqValid)
                begin
                    s_d.ce0b = isSem; // RL1 RL17
                    s_d.ce1  = ~isSem; // RL1
                    s_d.semb = ~isSem; // RL17
                    s_d.rnw  = ~isWr;
                    s_d.oeb  = isWr; // RL12
                    s_d.doe  = isWr; // RL20
                    s_d.ubb  = ~(reqUpper | isSem); // RL3
                    s_d.lbb  = ~(reqLower | isSem); // RL4
                    s_d.addr = reqAddr;
                    s_d.dout = reqData;
                    if (isSem)
                    begin
                        // Only bit 0 reaches a latch; zero the rest for clean compares
                        s_d.addr = {{(AW-`DPSA_SEM_AW){1'b0}}, reqAddr[`DPSA_SEM_AW-1:0]};
                        s_d.dout = {{(DW-1){1'b0}}, reqData[`DPSA_SEM_BIT]}; // RL17
                    end
                    if (reqCmd == DPSA_MBX_RD)
                        s_d.addr = mbxAddr(1'b0); // RL16
                    if (reqCmd == DPSA_MBX_WR)
                        s_d.addr = mbxAddr(1'b1); // RL16
                    s_d.tmrLoad  = isWr ? TW'(WR_CYC) : TW'(RD_CYC); // RL14
                    s_d.tmrStart = 1'b1;
                    s_d.state    = ST_ACC;
                end
            ST_ACC:
                if (!s_q.tmrStart && tmrIf.done)
                begin
                    // Strobe and select drop on one edge, data still driven
                    if (s_q.rnw)
                        s_d.rdata = dataIn; // RL14
                    s_d.busyHit = s_q.semb & ~busyIn_b; // RL6 RL7 RL8
                    s_d.rnw  = 1'b1; // RL13
                    s_d.ce0b = 1'b1; // RL11 RL13
                    s_d.ce1  = 1'b0;
                    s_d.semb = 1'b1;
                    s_d.oeb  = 1'b1;
                    s_d.ubb  = 1'b1;
                    s_d.lbb  = 1'b1;
                    s_d.state = ST_HOLD;
                end
            ST_HOLD:
            begin
                // Data held one cycle past the terminating edge
                s_d.doe       = 1'b0; // RL13
                s_d.respValid = 1'b1;
                s_d.tmrLoad   = TW'(GAP_CYC);
                s_d.tmrStart  = 1'b1;
                s_d.state     = ST_GAP;
            end
            ST_GAP:
                if (!s_q.tmrStart && tmrIf.done)
                    s_d.state = ST_IDLE;
        endcase
        s_d.ready = (s_d.state == ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= RST_ST;
        else
            s_q <= s_d;
    end

    assign tmrIf.start = s_q.tmrStart;
    assign tmrIf.load  = s_q.tmrLoad;

    dpsa_timer #(.CW(TW)) uTmr (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .tmr     (tmrIf)
    );

    assign reqReady              = s_q.ready;
    assign respValid             = s_q.respValid;
    assign respData              = s_q.rdata;
    assign respBusyHit           = s_q.busyHit;
    assign mbxIrq                = s_q.irq;
    assign portSelectLowActive_b = s_q.ce0b;
    assign portSelectHighActive  = s_q.ce1;
    assign readNotWrite          = s_q.rnw;
    assign outEnable_b           = s_q.oeb;
    assign upperByteGate_b       = s_q.ubb;
    assign lowerByteGate_b       = s_q.lbb;
    assign tokenLatchSelect_b    = s_q.semb;
    assign addrOut               = s_q.addr;
    assign dataOut               = s_q.dout;
    assign dataOe                = s_q.doe;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_sel_pair: assert property (portSelectLowActive_b == !portSelectHighActive) // RL1
        else $error("chip select pins disagree");
    a_sem_excl: assert property (!tokenLatchSelect_b |-> portSelectLowActive_b // RL17
        && dataOut[DW-1:1] == '0 && addrOut[AW-1:`DPSA_SEM_AW] == '0)
        else $error("semaphore access with chip select or stray bits");
    a_write_end: assert property ($rose(readNotWrite) && dataOe |-> // RL13
        portSelectLowActive_b && tokenLatchSelect_b && $stable(dataOut) ##1 !dataOe)
        else $error("write not ended cleanly");
    a_read_flow: assert property ($rose(outEnable_b) |-> $past(s_q.rdCnt) >= RD_CYC) // RL14
        else $error("read sampled before flowthrough time");
    a_no_fight: assert property (!outEnable_b |-> !dataOe && readNotWrite) // RL20
        else $error("host drives data while device may drive");
    a_idle_down: assert property (reqReady |-> portSelectLowActive_b // RL11
        && tokenLatchSelect_b)
        else $error("port selected while idle");
    a_resp_time: assert property (reqValid && reqReady |-> ##[3:600] respValid)
        else $error("no answer in time");
    a_busy_resp: assert property ($changed(respBusyHit) |=> respValid) // RL6
        else $error("busy flag out of step");

    c_write: cover property (reqValid && reqReady && reqCmd == DPSA_WRITE);
    c_read_busy: cover property (respValid && respBusyHit);
    c_sem_write: cover property ($rose(readNotWrite) && !$past(tokenLatchSelect_b));
    c_mbx_irq: cover property ($rose(mbxIrq));

endmodule // dpsa_host

// ==== dpsa_pkg.sv ====
package dpsa_pkg;

    typedef enum logic [2:0] {
        DPSA_READ   = 3'h0,
        DPSA_WRITE  = 3'h1,
        DPSA_SEM_RD = 3'h2,
        DPSA_SEM_WR = 3'h3,
        DPSA_MBX_RD = 3'h4,
        DPSA_MBX_WR = 3'h5
    } dpsa_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ACC  = 4'h2,
        ST_HOLD = 4'h4,
        ST_GAP  = 4'h8
    } dpsa_state_t;

endpackage

// ==== dpsa_timer.sv ====
`timescale 1ns/1ns
`include "dpsa_consts.svh"
module dpsa_timer #(
    parameter int CW = `DPSA_TMR_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control side
    dpsa_tmr_if.tmr  tmr
);
    import dpsa_pkg::*;

    typedef struct packed {
        logic [CW-1:0] cnt;
    } dpsa_tmr_st_t;

    dpsa_tmr_st_t s_q;
    dpsa_tmr_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (tmr.start)
            s_d.cnt = tmr.load;
        else if (s_q.cnt != '0)
            s_d.cnt = s_q.cnt - 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tmr.done = (s_q.cnt == '0);

    a_tmr_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tmr.start |=> s_q.cnt == $past(tmr.load))
        else $error("timer did not load");
    a_tmr_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !tmr.start && s_q.cnt != '0 |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
        else $error("timer did not count down");

endmodule // dpsa_timer

// ==== dpsa_tmr_if.sv ====
`timescale 1ns/1ns
interface dpsa_tmr_if #(parameter int CW = 8);
    logic          start;
    logic [CW-1:0] load;
    logic          done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

// ==== dual_port_sram_arbiter_test.sv ====
`timescale 1ns/1ns
module dual_port_sram_arbiter_test;
    import dpsa_pkg::*;
    logic sys_clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqUpper = 1'b0, reqLower = 1'b0;
    dpsa_cmd_t reqCmd = DPSA_READ;
    logic [14:0] reqAddr = 15'h0000, addrOut;
    logic [15:0] reqData = 16'h0000, respData, dataOut, dataIn;
    logic reqReady, respValid, respBusyHit, mbxIrq, portSelectLowActive_b;
    logic portSelectHighActive, readNotWrite, outEnable_b, upperByteGate_b;
    logic lowerByteGate_b, tokenLatchSelect_b, dataOe, busyIn_b, intIn_b;
    logic peerBusy = 1'b0, peerMbxWr = 1'b0;
    logic [7:0] peerSem = 8'h00;
    int n_errors = 0, comparisons = 0, seed;
    logic [14:0] a;
    logic [15:0] d, d2;
    logic u, l;

    always #5 sys_clk = ~sys_clk;

    dpsa_host u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reqValid(reqValid), .reqCmd(reqCmd),
        .reqAddr(reqAddr), .reqData(reqData), .reqUpper(reqUpper), .reqLower(reqLower),
        .reqReady(reqReady), .respValid(respValid), .respData(respData),
        .respBusyHit(respBusyHit), .mbxIrq(mbxIrq),
        .portSelectLowActive_b(portSelectLowActive_b),
        .portSelectHighActive(portSelectHighActive), .readNotWrite(readNotWrite),
        .outEnable_b(outEnable_b), .upperByteGate_b(upperByteGate_b),
        .lowerByteGate_b(lowerByteGate_b), .tokenLatchSelect_b(tokenLatchSelect_b),
        .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
        .busyIn_b(busyIn_b), .intIn_b(intIn_b));
    dpsa_dev_model u_dev (.sys_clk(sys_clk), .csLo_b(portSelectLowActive_b),
        .csHi(portSelectHighActive), .rnw(readNotWrite), .oe_b(outEnable_b),
        .ub_b(upperByteGate_b), .lb_b(lowerByteGate_b), .sem_b(tokenLatchSelect_b),
        .addr(addrOut), .wdata(dataOut), .rdata(dataIn), .busy_b(busyIn_b),
        .int_b(intIn_b), .peerBusy(peerBusy), .peerSem(peerSem), .peerMbxWr(peerMbxWr));

    function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic hi, logic lo);
        return {hi ? n[15:8] : o[15:8], lo ? n[7:0] : o[7:0]};
    endfunction

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits bounded; a hang shows up as a missing answer
    task automatic run(dpsa_cmd_t c, logic [14:0] ad, logic [15:0] dt, logic hi, logic lo);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 40);
        reqCmd <= c;
        reqAddr <= ad;
        reqData <= dt;
        reqUpper <= hi;
        reqLower <= lo;
        reqValid <= 1'b1;
        @(posedge sys_clk);
        reqValid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (respValid !== 1'b1 && n < 40);
        check("answer", 16'h0001, {15'h0000, respValid});
        check("idle pins", 16'h0004, {portSelectLowActive_b, portSelectHighActive, dataOe});
    endtask

    task automatic summarize();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end

    initial
    begin
        seed = $urandom(240);
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($urandom);
            d = 16'($urandom);
            d2 = 16'($urandom);
            {u, l} = 2'($urandom);
            run(DPSA_WRITE, a, d, 1'b1, 1'b1);
            run(DPSA_WRITE, a, d2, u, l);
            run(DPSA_READ, a, 16'h0000, 1'b1, 1'b1);
            check("read data", merge(d, d2, u, l), respData);
        end
        peerBusy <= 1'b1;
        run(DPSA_READ, a, 16'h0000, 1'b1, 1'b1);
        check("busy hit", 16'h0001, {15'h0000, respBusyHit});
        peerBusy <= 1'b0;
        run(DPSA_READ, a, 16'h0000, 1'b1, 1'b1);
        check("busy clear", 16'h0000, {15'h0000, respBusyHit});
        // Junk in the upper address and data bits must not matter
        run(DPSA_SEM_WR, 15'h7FF3, 16'hFFFE, 1'b0, 1'b0);
        run(DPSA_SEM_RD, 15'h0003, 16'h0000, 1'b0, 1'b0);
        check("sem grant", 16'h0000, respData);
        peerSem <= 8'h20;
        run(DPSA_SEM_WR, 15'h0005, 16'h0000, 1'b0, 1'b0);
        run(DPSA_SEM_RD, 15'h0005, 16'h0000, 1'b0, 1'b0);
        check("sem held", 16'hFFFF, respData);
        peerSem <= 8'h00;
        run(DPSA_SEM_RD, 15'h0005, 16'h0000, 1'b0, 1'b0);
        check("sem pending", 16'h0000, respData);
        run(DPSA_SEM_WR, 15'h0003, 16'h0001, 1'b0, 1'b0);
        run(DPSA_SEM_RD, 15'h0003, 16'h0000, 1'b0, 1'b0);
        check("sem free", 16'hFFFF, respData);
        run(DPSA_WRITE, 15'h7FFE, 16'hA55A, 1'b1, 1'b1);
        peerMbxWr <= 1'b1;
        @(posedge sys_clk);
        peerMbxWr <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("irq raised", 16'h0001, {15'h0000, mbxIrq});
        run(DPSA_MBX_WR, 15'h0000, 16'h3CC3, 1'b1, 1'b1);
        run(DPSA_READ, 15'h7FFF, 16'h0000, 1'b1, 1'b1);
        check("peer mailbox", 16'h3CC3, respData);
        check("irq kept", 16'h0001, {15'h0000, mbxIrq});
        run(DPSA_MBX_RD, 15'h0000, 16'h0000, 1'b1, 1'b1);
        check("own mailbox", 16'hA55A, respData);
        repeat (3) @(posedge sys_clk);
        check("irq cleared", 16'h0000, {15'h0000, mbxIrq});
        summarize();
    end
endmodule // dual_port_sram_arbiter_test
